// *** ccp_tb_params.svh ***
/*
  Offsets, field positions, reset values and prescale figures for the
  time-base control block. Assumes a 12-bit APB byte address.
*/
`ifndef CCP_TB_PARAMS_SVH
`define CCP_TB_PARAMS_SVH

// Register byte offsets
`define TBC_OFF_CTRL 12'h000
`define TBC_OFF_STAT 12'h004
`define TBC_OFF_COUNT 12'h008

// Field positions in the control word
`define TBC_BIT_ON 15
`define TBC_BIT_GAP 14
`define TBC_BIT_IDLE_HALT 13
`define TBC_BIT_SLEEP_RUN 12
`define TBC_BIT_SYNC 11
`define TBC_SRC_HI 10
`define TBC_SRC_LO 8
`define TBC_PS_HI 7
`define TBC_PS_LO 6
`define TBC_BIT_WIDE 5
`define TBC_BIT_CAPTURE_COMPARE_SELECT 4
`define TBC_MODE_HI 3
`define TBC_MODE_LO 0

// Reset values
`define TBC_CTRL_RESET 16'h0000
`define TBC_DATA_RESET 32'h0000_0000

// Last prescaler count for each divide ratio (ratio minus one)
`define TBC_PS_LAST_1 6'h00
`define TBC_PS_LAST_4 6'h03
`define TBC_PS_LAST_16 6'h0f
`define TBC_PS_LAST_64 6'h3f

// Source code that selects the system clock itself
`define TBC_SRC_SYSCLK 3'h0
// Compare-family function code for plain timer operation
`define TBC_MODE_TIMER 4'h0

`endif

// *** ccp_tb_pkg.sv ***
/*
  Types and shared decoding for the time-base control block.
  Assumes ccp_tb_params.svh is on the include path.
*/
`include "ccp_tb_params.svh"

package ccp_tb_pkg;

  // Control fields held by the block
  typedef struct packed {
    logic on;
    logic idle_halt;
    logic sleep_run;
    logic tick_sync;
    logic [2:0] tick_source_select;
    logic [1:0] prescale_select;
    logic wide_count_select;
    logic capture_compare_select;
    logic [3:0] func_mode;
  } ctrl_s;

  // Prescale ratio code to last prescaler count
  function automatic logic [5:0] prescale_last(input logic [1:0] code);
    logic [5:0] r;
    r = `TBC_PS_LAST_1;
    case (code)
      2'h1: r = `TBC_PS_LAST_4;
      2'h2: r = `TBC_PS_LAST_16;
      2'h3: r = `TBC_PS_LAST_64;
      default: r = `TBC_PS_LAST_1;
    endcase
    return r;
  endfunction

  // Packs the control fields into the 16-bit word; the gap bit is zero
  function automatic logic [15:0] ctrl_to_word(input ctrl_s c);
    logic [15:0] w;
    w = 16'h0000;
    w[`TBC_BIT_ON] = c.on;
    w[`TBC_BIT_IDLE_HALT] = c.idle_halt;
    w[`TBC_BIT_SLEEP_RUN] = c.sleep_run;
    w[`TBC_BIT_SYNC] = c.tick_sync;
    w[`TBC_SRC_HI:`TBC_SRC_LO] = c.tick_source_select;
    w[`TBC_PS_HI:`TBC_PS_LO] = c.prescale_select;
    w[`TBC_BIT_WIDE] = c.wide_count_select;
    w[`TBC_BIT_CAPTURE_COMPARE_SELECT] = c.capture_compare_select;
    w[`TBC_MODE_HI:`TBC_MODE_LO] = c.func_mode;
    return w;
  endfunction

  // Unpacks a written word; the gap bit is dropped
  function automatic ctrl_s word_to_ctrl(input logic [15:0] w);
    ctrl_s c;
    c.on = w[`TBC_BIT_ON];
    c.idle_halt = w[`TBC_BIT_IDLE_HALT];
    c.sleep_run = w[`TBC_BIT_SLEEP_RUN];
    c.tick_sync = w[`TBC_BIT_SYNC];
    c.tick_source_select = w[`TBC_SRC_HI:`TBC_SRC_LO];
    c.prescale_select = w[`TBC_PS_HI:`TBC_PS_LO];
    c.wide_count_select = w[`TBC_BIT_WIDE];
    c.capture_compare_select = w[`TBC_BIT_CAPTURE_COMPARE_SELECT];
    c.func_mode = w[`TBC_MODE_HI:`TBC_MODE_LO];
    return c;
  endfunction

endpackage

// *** ccp_time_base_control_low.sv ***
/*
  Time-base control word of a capture/compare/PWM/timer module with an
  APB slave, tick source selection and synchronisation, run gating for
  idle and sleep, and the family decode. Assumes idle_mode and
  sleep_mode come from the power controller on the same clock, and that
  tick_pins are asynchronous pins.
*/
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ccp_tb_params.svh"

// Summary of operation
// - Module runs only while module-on is set
// - Idle halts if asked; sleep runs if allowed
// - Three-bit code picks one of eight sources
// - Prescale divides by 1, 4, 16, 64
// - Wide-count bit selects 32 or 16 bits
// - Select bit picks capture or compare family
// - Compare code zero: timer, outputs disabled
module ccp_time_base_control_low #(
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  input wire logic [6:0] tick_pins,
  output logic run_active,
  output logic capture_active,
  output logic compare_active,
  output logic output_funcs_en,
  output logic [3:0] func_mode,
  output logic wide_count,
  output logic [31:0] count_value
);
  import ccp_tb_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ctrl_s ctrl;
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    logic [6:0] pin_s3;
    logic tick_aligned;
    logic run;
    logic cap;
    logic cmp;
    logic oen;
  } top_state_s;

  top_state_s st_reg;
  top_state_s st_next;
  tick_link_if lk ();

  logic [6:0] pin_rise;
  logic raw_tick;
  logic run_now;
  logic setup_phase;
  logic access_write;
  logic [31:0] stat_word;

  // Rising edges seen after the two-stage synchroniser
  assign pin_rise = st_reg.pin_s2 & ~st_reg.pin_s3;

  // Source pick; code zero is the system clock, so every cycle ticks
  always_comb begin
    raw_tick = 1'b0;
    if (st_reg.ctrl.tick_source_select == `TBC_SRC_SYSCLK) begin
      raw_tick = 1'b1;
    end else begin
      raw_tick = pin_rise[st_reg.ctrl.tick_source_select - 3'h1];
    end
  end

  // Run gating: off, idle with idle-halt and sleep without sleep-run each stop the count
  assign run_now = st_reg.ctrl.on &&
    !(idle_mode && st_reg.ctrl.idle_halt) &&
    !(sleep_mode && !st_reg.ctrl.sleep_run);

  assign setup_phase = psel && !penable;
  assign access_write = psel && penable && st_reg.pready && pwrite;
  assign stat_word = {28'h000_0000, st_reg.oen, st_reg.cmp, st_reg.cap,
    st_reg.run};

  // Next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.pin_s1 = tick_pins;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pin_s3 = st_reg.pin_s2;
    // Extra stage costs a cycle but gives a clean system-clock tick
    st_next.tick_aligned = raw_tick;
    st_next.run = run_now;
    st_next.cap = st_reg.ctrl.on && st_reg.ctrl.capture_compare_select;
    st_next.cmp = st_reg.ctrl.on && !st_reg.ctrl.capture_compare_select;
    // Plain timer code in the compare family keeps outputs off
    st_next.oen = st_reg.ctrl.on && !st_reg.ctrl.capture_compare_select &&
      (st_reg.ctrl.func_mode != `TBC_MODE_TIMER);
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    // Answer is prepared in setup so the access phase ends at once
    if (setup_phase) begin
      st_next.pready = 1'b1;
      st_next.prdata = `TBC_DATA_RESET;
      if (paddr == `TBC_OFF_CTRL) begin
        if (!pwrite) begin
          st_next.prdata = {16'h0000, ctrl_to_word(st_reg.ctrl)};
        end
      end else if (paddr == `TBC_OFF_STAT) begin
        if (!pwrite) begin
          st_next.prdata = stat_word;
        end
      end else if (paddr == `TBC_OFF_COUNT) begin
        if (!pwrite) begin
          st_next.prdata = lk.count;
        end
      end else begin
        st_next.pslverr = 1'b1;
      end
    end
    // Writes land at the access edge; gap bit is dropped by the unpack
    if (access_write && paddr == `TBC_OFF_CTRL) begin
      st_next.ctrl = word_to_ctrl(pwdata[15:0]);
    end
  end

  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Counter link; unsynchronised ticks skip the alignment stage
  assign lk.tick = st_reg.ctrl.tick_sync ? st_reg.tick_aligned
    : raw_tick;
  assign lk.run = st_reg.run;
  assign lk.clear = !st_reg.ctrl.on;
  assign lk.prescale_select = st_reg.ctrl.prescale_select;
  assign lk.wide_count_select = st_reg.ctrl.wide_count_select;

  time_base_counter u_counter (
    .clock(clock),
    .rstn(rstn),
    .lk(lk)
  );

  // Outputs straight from flip-flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign run_active = st_reg.run;
  assign capture_active = st_reg.cap;
  assign compare_active = st_reg.cmp;
  assign output_funcs_en = st_reg.oen;
  assign func_mode = st_reg.ctrl.func_mode;
  assign wide_count = st_reg.ctrl.wide_count_select;
  assign count_value = lk.count;

  property p_off_clear;
    @(posedge clock) disable iff (!rstn)
    (!st_reg.ctrl.on) |=> (count_value == 32'h0000_0000 && !run_active);
  endproperty
  a_off_clear: assert property (p_off_clear)
    else $error("count not cleared while module is off");

  property p_idle_halt;
    @(posedge clock) disable iff (!rstn)
    (idle_mode && st_reg.ctrl.idle_halt) |=> !run_active;
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("module ran in idle with idle-halt set");

  property p_sleep_stop;
    @(posedge clock) disable iff (!rstn)
    (sleep_mode && !st_reg.ctrl.sleep_run) |=> !run_active;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("module ran in sleep without sleep-run");

  property p_run_on;
    @(posedge clock) disable iff (!rstn)
    (st_reg.ctrl.on && !idle_mode && !sleep_mode) |=> run_active;
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("enabled module not running in normal mode");

  property p_sync_delay;
    @(posedge clock) disable iff (!rstn)
    (st_reg.ctrl.tick_sync && $stable(st_reg.ctrl)) |->
      (lk.tick == $past(raw_tick));
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchronised tick not one cycle behind source");

  property p_sysclk_tick;
    @(posedge clock) disable iff (!rstn)
    (st_reg.ctrl.tick_source_select == 3'h0 && !st_reg.ctrl.tick_sync)
      |-> lk.tick;
  endproperty
  a_sysclk_tick: assert property (p_sysclk_tick)
    else $error("system clock source failed to tick every cycle");

  property p_family;
    @(posedge clock) disable iff (!rstn)
    st_reg.ctrl.on |=> (capture_active == $past(
      st_reg.ctrl.capture_compare_select) && compare_active ==
      !capture_active);
  endproperty
  a_family: assert property (p_family)
    else $error("family outputs disagree with select bit");

  property p_timer_quiet;
    @(posedge clock) disable iff (!rstn)
    (!st_reg.ctrl.capture_compare_select &&
     st_reg.ctrl.func_mode == 4'h0) |=> !output_funcs_en;
  endproperty
  a_timer_quiet: assert property (p_timer_quiet)
    else $error("output functions on in plain timer code");

  property p_gap_zero;
    @(posedge clock) disable iff (!rstn)
    (setup_phase && !pwrite && paddr == `TBC_OFF_CTRL) |=>
      (pready && prdata[14] == 1'b0);
  endproperty
  a_gap_zero: assert property (p_gap_zero)
    else $error("unused control bit read back nonzero");

  property p_write_lands;
    @(posedge clock) disable iff (!rstn)
    (access_write && paddr == `TBC_OFF_CTRL) |=>
      (ctrl_to_word(st_reg.ctrl) == ($past(pwdata[15:0]) & 16'hbfff));
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("control write did not take effect");

  property p_idle_run;
    @(posedge clock) disable iff (!rstn)
    (st_reg.ctrl.on && idle_mode && !st_reg.ctrl.idle_halt &&
     !sleep_mode) |=> run_active;
  endproperty
  a_idle_run: assert property (p_idle_run)
    else $error("module halted in idle with idle-halt clear");

  property p_sleep_run;
    @(posedge clock) disable iff (!rstn)
    (st_reg.ctrl.on && sleep_mode && st_reg.ctrl.sleep_run &&
     !(idle_mode && st_reg.ctrl.idle_halt)) |=> run_active;
  endproperty
  a_sleep_run: assert property (p_sleep_run)
    else $error("module halted in sleep with sleep-run set");

  // Pin ticks lag the pin by the two synchroniser stages plus detect
  property p_pin_tick;
    @(posedge clock) disable iff (!rstn)
    (st_reg.ctrl.tick_source_select != `TBC_SRC_SYSCLK &&
     !st_reg.ctrl.tick_sync) |->
      (lk.tick == |((($past(tick_pins, 2) & ~$past(tick_pins, 3)) >>
        (st_reg.ctrl.tick_source_select - 3'h1)) & 7'h01));
  endproperty
  a_pin_tick: assert property (p_pin_tick)
    else $error("pin tick does not follow the selected pin edge");

  property p_off_quiet;
    @(posedge clock) disable iff (!rstn)
    !st_reg.ctrl.on |=> (!capture_active && !compare_active &&
      !output_funcs_en);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("family outputs active while module is off");

  property p_capture_quiet;
    @(posedge clock) disable iff (!rstn)
    (st_reg.ctrl.on && st_reg.ctrl.capture_compare_select) |=>
      (capture_active && !compare_active && !output_funcs_en);
  endproperty
  a_capture_quiet: assert property (p_capture_quiet)
    else $error("compare outputs active in capture family");

  // Guards against output enables stuck low passing the quiet check
  property p_compare_out;
    @(posedge clock) disable iff (!rstn)
    (st_reg.ctrl.on && !st_reg.ctrl.capture_compare_select &&
     st_reg.ctrl.func_mode != `TBC_MODE_TIMER) |=> output_funcs_en;
  endproperty
  a_compare_out: assert property (p_compare_out)
    else $error("output functions off in a compare code");
endmodule

`default_nettype wire

// *** tb.sv ***
/*
  Self-checking bench for the time-base control block: APB traffic,
  run gating, family decode, tick sources, prescaler and count width.
  Assumes the design files and ccp_tb_params.svh are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccp_tb_params.svh"

module tb;
  import ccp_tb_pkg::*;

  typedef struct packed {
    logic care;
    logic [31:0] data;
    logic err;
    logic [4:0] side;
  } note_s;

  logic clock, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, count_value, w, c1, c2, seed;
  logic idle_mode, sleep_mode, run_active, capture_active;
  logic compare_active, output_funcs_en, wide_count;
  logic [6:0] tick_pins;
  logic [3:0] func_mode;
  logic [15:0] shadow;
  note_s notes[$];
  note_s nt;
  int n_fail, n_checks, i, j;
  logic [31:0] outs;

  ccp_time_base_control_low i_ccp_time_base_control_low (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .tick_pins(tick_pins),
    .run_active(run_active), .capture_active(capture_active),
    .compare_active(compare_active), .output_funcs_en(output_funcs_en),
    .func_mode(func_mode), .wide_count(wide_count),
    .count_value(count_value)
  );

  // Family and run outputs in the status layout, for direct checks
  assign outs = {28'h000_0000, output_funcs_en, compare_active,
    capture_active, run_active};

  // Free-running system clock
  always #2 clock = ~clock;

  task check32(input logic [31:0] exp, input logic [31:0] act);
    n_checks++;
    if (act !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask

  task end_of_test;
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One APB transfer; the master never assumes the wait-state count
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic care, input logic [31:0] exp, input logic err,
           output logic [31:0] rd);
    int t;
    t = 0;
    notes.push_back({care, exp, err, shadow[5], shadow[3:0]});
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_fail++;
      end_of_test();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Control write; the gap bit never lands in the shadow copy
  task wr_ctrl(input logic [31:0] d);
    apb(1'b1, `TBC_OFF_CTRL, d, 1'b0, 32'h0000_0000, 1'b0, w);
    shadow = d[15:0] & 16'hbfff;
  endtask

  task rd_exp(input logic [11:0] a, input logic [31:0] e,
              input logic err);
    apb(1'b0, a, 32'h0000_0000, 1'b1, e, err, w);
  endtask

  task rd_count(output logic [31:0] v);
    apb(1'b0, `TBC_OFF_COUNT, 32'h0000_0000, 1'b0, 32'h0, 1'b0, v);
  endtask

  // Status word expected from the control word and power state
  function automatic logic [31:0] stat_exp(input logic [15:0] c);
    logic run;
    run = c[15] & ~(idle_mode & c[13]) & ~(sleep_mode & ~c[12]);
    return {28'h0, ~c[4] & (c[3:0] != 4'h0), c[15] & ~c[4],
            c[15] & c[4], run};
  endfunction

  // Completed transfers are judged against the oldest note
  always @(posedge clock) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        n_fail++;
      end else begin
        nt = notes.pop_front();
        if (nt.care) check32(nt.data, prdata);
        check32({31'h0, nt.err}, {31'h0, pslverr});
        check32({27'h0, nt.side}, {27'h0, wide_count, func_mode});
      end
    end
  end

  // Watchdog: the whole run needs about 70000 cycles
  initial begin
    repeat (90000) @(posedge clock);
    n_fail++;
    end_of_test();
  end

  // Main sequence
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, idle_mode, sleep_mode} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tick_pins = 7'h00;
    shadow = 16'h0000;
    n_fail = 0;
    n_checks = 0;
    seed = $urandom(32'h619c);
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd_exp(`TBC_OFF_CTRL, 32'h0000_0000, 1'b0);
    rd_exp(`TBC_OFF_STAT, 32'h0000_0000, 1'b0);
    rd_exp(`TBC_OFF_COUNT, 32'h0000_0000, 1'b0);
    // Gap bit and upper half are written as ones but read as zero
    w = $urandom | 32'hffff_4000;
    w[15] = 1'b0;
    wr_ctrl(w);
    rd_exp(`TBC_OFF_CTRL, {16'h0, shadow}, 1'b0);
    // Unmapped place refuses and keeps control unchanged
    apb(1'b1, 12'h00c, 32'h0000_ffff, 1'b0, 32'h0, 1'b1, w);
    rd_exp(12'h00c, 32'h0000_0000, 1'b1);
    rd_exp(`TBC_OFF_CTRL, {16'h0, shadow}, 1'b0);
    // Every family and function code, random width
    for (i = 0; i < 32; i++) begin
      wr_ctrl(32'h0000_8000 | i | ($urandom & 32'h0000_0020));
      rd_exp(`TBC_OFF_STAT, stat_exp(shadow), 1'b0);
      check32(stat_exp(shadow), outs);
    end
    // Idle and sleep gating; reads are three cycles apart
    for (j = 0; j < 16; j++) begin
      @(posedge clock);
      idle_mode <= j[3];
      sleep_mode <= j[2];
      wr_ctrl(32'h0000_8000 | (j[1] << 13) | (j[0] << 12));
      rd_exp(`TBC_OFF_STAT, stat_exp(shadow), 1'b0);
      check32(stat_exp(shadow), outs);
      rd_count(c1);
      rd_count(c2);
      check32(stat_exp(shadow) & 32'h1 ? 32'h3 : 32'h0, c2 - c1);
    end
    @(posedge clock);
    {idle_mode, sleep_mode} <= 2'b00;
    // Prescaler: 256 cycles give exactly 256/ratio steps
    for (i = 0; i < 4; i++) begin
      wr_ctrl(32'h0000_8000 | (i << 6));
      rd_count(c1);
      repeat (253) @(posedge clock);
      rd_count(c2);
      check32(32'd256 >> (2 * i), c2 - c1);
    end
    wr_ctrl(32'h0000_0000);
    rd_exp(`TBC_OFF_COUNT, 32'h0000_0000, 1'b0);
    // Pin sources, random sync; unselected pins toggle as noise
    for (i = 1; i < 8; i++) begin
      wr_ctrl(32'h0000_0000);
      wr_ctrl(32'h0000_8000 | (i << 8) | ($urandom & 32'h0000_0800));
      rd_count(c1);
      for (j = 0; j < 10; j++) begin
        repeat (4) begin
          @(posedge clock);
          w = $urandom;
          w[i-1] = ~j[0];
          tick_pins <= w[6:0];
        end
      end
      @(posedge clock);
      tick_pins <= 7'h00;
      repeat (8) @(posedge clock);
      rd_count(c2);
      check32(32'h5, c2 - c1);
    end
    // Wide count passes 16 bits; narrowing forces the upper half to 0
    wr_ctrl(32'h0000_0000);
    wr_ctrl(32'h0000_8020);
    rd_count(c1);
    repeat (65533) @(posedge clock);
    rd_count(c2);
    check32(c1 + 32'h0001_0000, c2);
    wr_ctrl(32'h0000_8000);
    rd_count(c1);
    check32((c2 + 32'h6) & 32'h0000_ffff, c1);
    end_of_test();
  end
endmodule

`default_nettype wire

// *** tick_link_if.sv ***
/*
  Carrier between the control block and its time-base counter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface tick_link_if;
  logic tick;
  logic run;
  logic clear;
  logic [1:0] prescale_select;
  logic wide_count_select;
  logic [31:0] count;

  modport ctl (
    output tick, run, clear, prescale_select, wide_count_select,
    input count
  );
  modport cnt (
    input tick, run, clear, prescale_select, wide_count_select,
    output count
  );
endinterface

`default_nettype wire

// *** time_base_counter.sv ***
/*
  Prescaler and 16/32-bit time-base counter.
  Assumes tick pulses are already aligned to the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccp_tb_params.svh"

module time_base_counter (
  input wire logic clock,
  input wire logic rstn,
  tick_link_if.cnt lk
);
  import ccp_tb_pkg::*;

  typedef struct packed {
    logic [5:0] pcnt;
    logic [1:0] ps_prev;
    logic [31:0] count;
  } cnt_state_s;

  cnt_state_s st_reg;
  cnt_state_s st_next;
  logic [5:0] last;

  assign last = prescale_last(lk.prescale_select);
  assign lk.count = st_reg.count;

  // Counting; a ratio change restarts the prescaler so no short period
  always_comb begin
    st_next = st_reg;
    st_next.ps_prev = lk.prescale_select;
    if (lk.clear) begin
      st_next.pcnt = 6'h00;
      st_next.count = `TBC_DATA_RESET;
    end else if (lk.prescale_select != st_reg.ps_prev) begin
      st_next.pcnt = 6'h00;
    end else if (lk.run && lk.tick) begin
      if (st_reg.pcnt >= last) begin
        st_next.pcnt = 6'h00;
        if (lk.wide_count_select) begin
          st_next.count = st_reg.count + 32'h0000_0001;
        end else begin
          st_next.count = {16'h0000, st_reg.count[15:0] + 16'h0001};
        end
      end else begin
        st_next.pcnt = st_reg.pcnt + 6'h01;
      end
    end
    if (!lk.wide_count_select) begin
      st_next.count[31:16] = 16'h0000;
    end
  end

  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  property p_ps_step;
    @(posedge clock) disable iff (!rstn)
    (!lk.clear && lk.run && lk.tick && st_reg.pcnt == last &&
     lk.prescale_select == st_reg.ps_prev)
      |=> (st_reg.count[15:0] == $past(st_reg.count[15:0]) + 16'h0001);
  endproperty
  a_ps_step: assert property (p_ps_step)
    else $error("prescaler terminal tick did not step the count");

  property p_ps_hold;
    @(posedge clock) disable iff (!rstn)
    (!lk.clear && st_reg.pcnt != last) |=> $stable(st_reg.count[15:0]);
  endproperty
  a_ps_hold: assert property (p_ps_hold)
    else $error("count stepped before the prescaler ran out");

  property p_narrow;
    @(posedge clock) disable iff (!rstn)
    !lk.wide_count_select |=> (st_reg.count[31:16] == 16'h0000 ||
      lk.wide_count_select);
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("upper count half nonzero in 16-bit mode");
endmodule

`default_nettype wire
